// ==== rtl/pfw_mem.sv ====
/*
 Internal window memory, 2K bytes, one write port and a registered read.
 Assumes the caller gates the write enable by the window decode.
*/
`timescale 1ns/1ps
module pfw_mem (
   input  wire logic                            clk_in,
   input  wire logic                            we_in,
   input  wire logic [pfw_pkg::WIN_ADDR_W-1:0]  addr_in,
   input  wire logic [7:0]                      wdata_in,
   output logic      [7:0]                      rdata_out
);
   import pfw_pkg::*;
   logic [7:0] mem [0:(1<<WIN_ADDR_W)-1];
   logic [7:0] rdata_reg;
   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem[addr_in] <= wdata_in;
      end
      rdata_reg <= mem[addr_in];
   end
   assign rdata_out = rdata_reg;
endmodule

// ==== rtl/pfw_pkg.sv ====
/*
 Constants for the power-fail notifier and memory window gate.
 Assumes a 250 MHz clock and a host bus sampled synchronously.
*/
package pfw_pkg;
   localparam int          CLK_MHZ          = 250;
   localparam int          SAMPLE_NS        = 25000;
   localparam int          SAMPLE_MAX_NS    = 40000;
   localparam int          SAMPLE_CYC       = SAMPLE_NS * CLK_MHZ / 1000;
   localparam int          SAMPLE_MAX_CYC   = SAMPLE_MAX_NS * CLK_MHZ / 1000;
   localparam int          CNT_W            = 14;
   localparam int          VAL_COUNT        = 3;
   localparam int          NMI_PULSE_CYC    = 16;
   localparam int          WIN_SEQ_LEN      = 3;
   localparam logic [15:0] TOGGLE_ADDR_RST  = 16'h07FF;
   localparam logic [4:0]  WIN_BASE_RST     = 5'h1F;
   localparam int          CTRL_SENSE_BIT   = 7;
   localparam int          CTRL_THRESH_BIT  = 6;
   localparam int          CTRL_NOAUTO_BIT  = 3;
   localparam logic [7:0]  CTRL_RST         = 8'h00;
   localparam logic [7:0]  MEM_DATA_RST     = 8'h00;
   localparam int          WIN_ADDR_W       = 11;
   typedef enum logic [1:0] {
      PFW_ST_GOOD = 2'b01,
      PFW_ST_FAIL = 2'b10
   } pfw_state_t;
endpackage

// ==== rtl/pfw_top.sv ====
/*
 Power-fail and recovery notifier with an internal memory window gate.
 Assumes comparator results and host bus strobes are synchronous to clk_in.
*/
`timescale 1ns/1ps
module pfw_top (
   input  wire logic        clk_in,
   input  wire logic        resetn_in,
   input  wire logic        main_below_lo_in,
   input  wire logic        main_below_hi_in,
   input  wire logic        auxiliary_sense_input,
   input  wire logic        reset_thresh_ok_in,
   input  wire logic        bus_access_in,
   input  wire logic        bus_write_in,
   input  wire logic [15:0] bus_addr_in,
   input  wire logic [7:0]  bus_wdata_in,
   input  wire logic        ctrl_write_in,
   input  wire logic [7:0]  ctrl_wdata_in,
   input  wire logic        keepalive_strobe_input,
   output logic             nmi_n_out,
   output logic             nmi_is_fail_out,
   output logic             external_chip_enable_out,
   output logic             internal_select_out,
   output logic [7:0]       internal_rdata_out,
   output logic             window_open_out,
   output logic             semi_closed_out,
   output logic             watchdog_restart_out,
   output logic [7:0]       supervisor_control_reg_out
);
   import pfw_pkg::*;

   typedef struct packed {
      logic [CNT_W-1:0] tick_cnt;
      logic [1:0]       val_cnt;
      pfw_state_t       det;
      logic [4:0]       nmi_cnt;
      logic             nmi_n;
      logic             nmi_fail;
      logic [7:0]       ctrl;
      logic [7:0]       ctrl_pend;
      logic             pend_valid;
      logic             win_open;
      logic             semi;
      logic             open_at_fail;
      logic             rst_ok_d;
      logic [1:0]       seq_cnt;
      logic             wd_restart;
      logic             ext_ce_n;
      logic             int_sel;
   } pfw_regs_t;

   pfw_regs_t  s_reg;
   pfw_regs_t  s_next;
   logic       tick;
   logic       below;
   logic       in_win;
   logic       mem_we;
   logic [7:0] mem_rdata;

   // Interval below 40 us cap by construction
   assign tick   = (s_reg.tick_cnt == CNT_W'(SAMPLE_CYC - 1));
   assign in_win = (bus_addr_in[15:11] == WIN_BASE_RST);
   assign mem_we = bus_access_in && bus_write_in && in_win && s_reg.win_open;

   always_comb begin
      // Sense select, threshold select
      if (s_reg.ctrl[CTRL_SENSE_BIT]) begin
         below = auxiliary_sense_input;
      end else if (s_reg.ctrl[CTRL_THRESH_BIT]) begin
         below = main_below_hi_in;
      end else begin
         below = main_below_lo_in;
      end
   end

   always_comb begin
      s_next            = s_reg;
      s_next.wd_restart = keepalive_strobe_input;
      s_next.rst_ok_d   = reset_thresh_ok_in;
      s_next.tick_cnt   = tick ? '0 : s_reg.tick_cnt + CNT_W'(1);
      if (s_reg.nmi_cnt != 5'h00) begin
         s_next.nmi_cnt = s_reg.nmi_cnt - 5'h01;
      end else begin
         s_next.nmi_n = 1'b1;
      end
      if (tick) begin
         // Only samples opposite the current state count
         if ((s_reg.det == PFW_ST_GOOD) == below) begin
            if (s_reg.val_cnt == 2'(VAL_COUNT - 1)) begin
               s_next.val_cnt  = 2'h0;
               s_next.nmi_n    = 1'b0;
               s_next.nmi_cnt  = 5'(NMI_PULSE_CYC);
               s_next.nmi_fail = below;
               s_next.det      = below ? PFW_ST_FAIL : PFW_ST_GOOD;
               if (below) begin
                  s_next.open_at_fail = s_reg.win_open;
                  if (!s_reg.ctrl[CTRL_NOAUTO_BIT]) begin
                     s_next.win_open = 1'b1;
                  end
               end
            end else begin
               s_next.val_cnt = s_reg.val_cnt + 2'h1;
            end
         end else begin
            s_next.val_cnt = 2'h0;
         end
      end
      // Power-up pass of reset threshold
      if (reset_thresh_ok_in && !s_reg.rst_ok_d) begin
         if (!s_reg.ctrl[CTRL_NOAUTO_BIT]) begin
            s_next.win_open = 1'b1;
         end else if (s_reg.open_at_fail) begin
            s_next.semi     = 1'b1;
            s_next.win_open = 1'b0;
         end
         s_next.open_at_fail = 1'b0;
      end
      // Staged until close
      if (ctrl_write_in) begin
         if (s_reg.win_open) begin
            s_next.ctrl_pend  = ctrl_wdata_in;
            s_next.pend_valid = 1'b1;
         end
      end
      if (bus_access_in) begin
         if (bus_write_in && bus_addr_in == TOGGLE_ADDR_RST) begin
            if (s_reg.seq_cnt == 2'(WIN_SEQ_LEN - 1)) begin
               s_next.seq_cnt    = 2'h0;
               s_next.wd_restart = 1'b1;
               if (s_reg.win_open || s_reg.semi) begin
                  s_next.win_open = 1'b0;
                  s_next.semi     = 1'b0;
                  if (s_reg.pend_valid) begin
                     s_next.ctrl       = s_reg.ctrl_pend;
                     s_next.pend_valid = 1'b0;
                  end
               end else begin
                  s_next.win_open = 1'b1;
               end
            end else begin
               s_next.seq_cnt = s_reg.seq_cnt + 2'h1;
            end
         end else if (bus_addr_in != TOGGLE_ADDR_RST || !bus_write_in) begin
            // A read of the toggle address (save step) also aborts
            s_next.seq_cnt = 2'h0;
         end
      end
      // Registered gate; one-cycle delay after address
      s_next.int_sel  = bus_access_in && in_win && s_reg.win_open;
      s_next.ext_ce_n = !(bus_access_in && !(in_win && s_reg.win_open));
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         s_reg              <= '0;
         s_reg.det          <= PFW_ST_GOOD;
         s_reg.nmi_n        <= 1'b1;
         s_reg.ctrl         <= CTRL_RST;
         s_reg.ctrl_pend    <= CTRL_RST;
         s_reg.ext_ce_n     <= 1'b1;
         // Idle level of a present supply; avoids a false power-up edge after reset
         s_reg.rst_ok_d     <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   pfw_mem u_mem (
      .clk_in    (clk_in),
      .we_in     (mem_we),
      .addr_in   (bus_addr_in[WIN_ADDR_W-1:0]),
      .wdata_in  (bus_wdata_in),
      .rdata_out (mem_rdata)
   );

   assign nmi_n_out                  = s_reg.nmi_n;
   assign nmi_is_fail_out            = s_reg.nmi_fail;
   assign external_chip_enable_out   = s_reg.ext_ce_n;
   assign internal_select_out        = s_reg.int_sel;
   assign internal_rdata_out         = mem_rdata;
   assign window_open_out            = s_reg.win_open;
   assign semi_closed_out            = s_reg.semi;
   assign watchdog_restart_out       = s_reg.wd_restart;
   assign supervisor_control_reg_out = s_reg.ctrl;
endmodule

// ==== verif/pfw_host_model.sv ====
/*
 Host bus model: single accesses and the window toggle routine.
 Assumes it changes its lines 1 ns after rising edges of clk_in.
*/
`timescale 1ns/1ps
module pfw_host_model (
   input  wire logic        clk_in,
   output logic             bus_access_out = 1'b0,
   output logic             bus_write_out = 1'b0,
   output logic [15:0]      bus_addr_out = 16'h0000,
   output logic [7:0]       bus_wdata_out = 8'h00
);
   task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_in);
      #1;
      bus_access_out = 1'b1;
      bus_write_out = wr;
      bus_addr_out = a;
      bus_wdata_out = d;
   endtask
   // Released lines show inverted values so stale ones never pass as valid
   task automatic idle();
      @(posedge clk_in);
      #1;
      bus_access_out = 1'b0;
      bus_write_out = ~bus_write_out;
      bus_addr_out = ~bus_addr_out;
      bus_wdata_out = ~bus_wdata_out;
   endtask
   task automatic toggle();
      acc(1'b0, 16'h07FF, 8'h00);
      repeat (3) acc(1'b1, 16'h07FF, 8'hFF);
      idle();
      acc(1'b1, 16'h07FF, 8'h5A);
      idle();
   endtask
endmodule

// ==== verif/pfw_top_properties.sv ====
/*
 Port checker for the power-fail notifier and window gate.
 Assumes it is bound onto pfw_top with one clock and sync reset.
*/
`timescale 1ns/1ps
module pfw_top_properties (
   input wire logic        clk_in,
   input wire logic        resetn_in,
   input wire logic        bus_access_in,
   input wire logic        bus_write_in,
   input wire logic [15:0] bus_addr_in,
   input wire logic        keepalive_strobe_input,
   input wire logic        nmi_n_out,
   input wire logic        nmi_is_fail_out,
   input wire logic        external_chip_enable_out,
   input wire logic        internal_select_out,
   input wire logic        window_open_out,
   input wire logic        semi_closed_out,
   input wire logic        watchdog_restart_out,
   input wire logic [7:0]  supervisor_control_reg_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   wire win_hit = bus_addr_in[15:11] == 5'h1F;
   nmi_width_a: assert property ($fell(nmi_n_out) |=> !nmi_n_out [*8]) else $error("nmi pulse short");
   fail_alternates_a: assert property ($fell(nmi_n_out) |-> nmi_is_fail_out != $past(nmi_is_fail_out))
      else $error("nmi kind did not alternate");
   toggle_restart_a: assert property ((bus_access_in && bus_write_in && bus_addr_in == 16'h07FF) [*3]
      |=> watchdog_restart_out) else $error("no restart after toggle");
   keepalive_copy_a: assert property (keepalive_strobe_input |=> watchdog_restart_out) else $error("keepalive lost");
   closed_external_a: assert property (bus_access_in && !window_open_out |=> !external_chip_enable_out
      && !internal_select_out) else $error("closed window not external");
   open_internal_a: assert property (bus_access_in && window_open_out && win_hit |=> internal_select_out
      && external_chip_enable_out) else $error("open window not internal");
   idle_disabled_a: assert property (!bus_access_in |=> external_chip_enable_out && !internal_select_out)
      else $error("enable without access");
   ctrl_staged_a: assert property (window_open_out && $past(window_open_out) |-> $stable(supervisor_control_reg_out))
      else $error("control changed while open");
   semi_closed_a: assert property (semi_closed_out |-> !window_open_out) else $error("semi-closed but open");
endmodule
bind pfw_top pfw_top_properties pfw_top_properties_inst (.*);

// ==== verif/tb_pfw_top.sv ====
/*
 Self-checking bench for pfw_top with the host bus model.
 Assumes the 25 us sample tick is fixed at 6250 cycles.
*/
`timescale 1ns/1ps
module tb_pfw_top;
   logic clk_in = 1'b0, resetn_in = 1'b0, lo = 1'b0, hi = 1'b1, aux = 1'b1, rst_ok = 1'b1;
   logic cw = 1'b0, ka = 1'b0;
   logic [7:0] cd = 8'h00;
   wire acc_w, wr_w;
   wire [15:0] addr_w;
   wire [7:0] wd_w;
   logic nmi_n, is_fail, ce_n, isel, win, semi, wdr;
   logic [7:0] rd, ctrl;
   int mismatches = 0, samples_checked = 0, n;
   always #2 clk_in = ~clk_in;
   pfw_host_model pfw_host_model_inst (.clk_in(clk_in), .bus_access_out(acc_w), .bus_write_out(wr_w),
      .bus_addr_out(addr_w), .bus_wdata_out(wd_w));
   pfw_top pfw_top_inst (.clk_in(clk_in), .resetn_in(resetn_in), .main_below_lo_in(lo), .main_below_hi_in(hi),
      .auxiliary_sense_input(aux), .reset_thresh_ok_in(rst_ok), .bus_access_in(acc_w), .bus_write_in(wr_w),
      .bus_addr_in(addr_w), .bus_wdata_in(wd_w), .ctrl_write_in(cw), .ctrl_wdata_in(cd),
      .keepalive_strobe_input(ka), .nmi_n_out(nmi_n), .nmi_is_fail_out(is_fail), .external_chip_enable_out(ce_n),
      .internal_select_out(isel), .internal_rdata_out(rd), .window_open_out(win), .semi_closed_out(semi),
      .watchdog_restart_out(wdr), .supervisor_control_reg_out(ctrl));
   task automatic stop_test();
      if (mismatches == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic step();
      @(posedge clk_in);
      #1;
   endtask
   // Bounded wait; a missing interrupt ends the run
   task automatic wait_nmi();
      for (n = 0; n < 20000 && nmi_n !== 1'b0; n++) step();
      if (n == 20000) begin
         mismatches++;
         stop_test();
      end
   endtask
   task automatic t_reset();
      chk(nmi_n, 1);
      chk(ce_n, 1);
      chk(win, 0);
      chk(ctrl, 8'h00);
      ka = 1'b1;
      step();
      ka = 1'b0;
      chk(wdr, 1);
      chk(win, 0);
      step();
      chk(wdr, 0);
   endtask
   task automatic t_gate_abort();
      pfw_host_model_inst.acc(1'b1, 16'hF800, 8'h11);
      pfw_host_model_inst.idle();
      chk(ce_n, 0);
      chk(isel, 0);
      pfw_host_model_inst.acc(1'b1, 16'h07FF, 8'hFF);
      pfw_host_model_inst.acc(1'b1, 16'h07FF, 8'hFF);
      pfw_host_model_inst.acc(1'b0, 16'h07FF, 8'h00);
      pfw_host_model_inst.acc(1'b1, 16'h07FF, 8'hFF);
      pfw_host_model_inst.idle();
      chk(win, 0);
   endtask
   task automatic t_config();
      pfw_host_model_inst.toggle();
      chk(win, 1);
      pfw_host_model_inst.acc(1'b1, 16'hF800, 8'h33);
      pfw_host_model_inst.acc(1'b0, 16'hF800, 8'h00);
      pfw_host_model_inst.idle();
      chk(isel, 1);
      chk(ce_n, 1);
      chk(rd, 8'h33);
      cw = 1'b1;
      cd = 8'h08;
      step();
      cw = 1'b0;
      step();
      chk(ctrl, 8'h00);
      pfw_host_model_inst.toggle();
      chk(ctrl, 8'h08);
      chk(win, 0);
      pfw_host_model_inst.toggle();
   endtask
   // High-threshold and aux inputs stay asserted; with control bits 7 and 6 clear only the main low comparator may count
   task automatic t_power();
      lo = 1'b1;
      wait_nmi();
      chk(n >= 12499, 1);
      chk(is_fail, 1);
      chk(win, 1);
      rst_ok = 1'b0;
      repeat (20) step();
      lo = 1'b0;
      rst_ok = 1'b1;
      wait_nmi();
      chk(is_fail, 0);
      chk(semi, 1);
      pfw_host_model_inst.toggle();
      chk(semi, 0);
   endtask
   initial begin
      repeat (10) @(posedge clk_in);
      #1;
      resetn_in = 1'b1;
      t_reset();
      t_gate_abort();
      t_config();
      t_power();
      stop_test();
   end
endmodule
